// File: hdl/tvio_pkg.sv
// Package with register map, field masks and carriers for the TV MCU I/O ports
package tvio_pkg;

	// Register byte offsets
	localparam logic [7:0] TVIO_OFF_A_DATA   = 8'h00;
	localparam logic [7:0] TVIO_OFF_A_DIR    = 8'h04;
	localparam logic [7:0] TVIO_OFF_A_PULL   = 8'h08;
	localparam logic [7:0] TVIO_OFF_A_PINS   = 8'h0c;
	localparam logic [7:0] TVIO_OFF_B_DATA   = 8'h10;
	localparam logic [7:0] TVIO_OFF_B_DIR    = 8'h14;
	localparam logic [7:0] TVIO_OFF_B_PULL   = 8'h18;
	localparam logic [7:0] TVIO_OFF_B_PINS   = 8'h1c;
	localparam logic [7:0] TVIO_OFF_C_DATA   = 8'h20;
	localparam logic [7:0] TVIO_OFF_C_DIR    = 8'h24;
	localparam logic [7:0] TVIO_OFF_C_PULL   = 8'h28;
	localparam logic [7:0] TVIO_OFF_C_PINS   = 8'h2c;
	localparam logic [7:0] TVIO_OFF_EDGE_SEL = 8'h30;
	localparam logic [7:0] TVIO_OFF_IRQ_STAT = 8'h34;
	localparam logic [7:0] TVIO_OFF_IRQ_MASK = 8'h38;

	// Implemented lines per port
	localparam logic [7:0] TVIO_A_LINES   = 8'hff;
	localparam logic [7:0] TVIO_B_LINES   = 8'h77;
	localparam logic [7:0] TVIO_C_LINES   = 8'hff;
	// Lines with a pull-up option
	localparam logic [7:0] TVIO_A_PULL_OK = 8'h0f;
	localparam logic [7:0] TVIO_B_PULL_OK = 8'h77;
	localparam logic [7:0] TVIO_C_PULL_OK = 8'h0f;
	// Lines that drive open-drain
	localparam logic [7:0] TVIO_A_OD      = 8'hf0;
	localparam logic [7:0] TVIO_B_OD      = 8'h00;
	localparam logic [7:0] TVIO_C_OD      = 8'hff;

	// Third port line positions
	localparam int TVIO_C_SER_CLK = 0;
	localparam int TVIO_C_SER_DAT = 1;
	localparam int TVIO_C_SER_STB = 3;
	localparam int TVIO_C_PWR     = 4;
	localparam int TVIO_C_REMOTE  = 6;

	// Interrupt status, mask and edge select bit positions
	localparam int TVIO_IRQ_PWR    = 0;
	localparam int TVIO_IRQ_REMOTE = 1;
	localparam int TVIO_IRQ_BITS   = 2;

	// Reset values
	localparam logic [7:0] TVIO_RST_BYTE = 8'h00;
	localparam logic [1:0] TVIO_RST_IRQ  = 2'h0;

	// AXI responses
	localparam logic [1:0] TVIO_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TVIO_RESP_SLVERR = 2'h2;

	// Software-side state of one port
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] pull;
	} tvio_port_t;

	// Pin-side drive of one port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} tvio_drive_t;

	localparam tvio_port_t TVIO_RST_PORT = '{data: 8'h00, dir: 8'h00, pull: 8'h00};

	// Write FSM states
	typedef enum logic [1:0] {
		TVIO_WR_IDLE = 2'b01,
		TVIO_WR_RESP = 2'b10
	} tvio_wr_state_t;

endpackage

// File: hdl/tvio_ports.sv
// Three general-purpose I/O ports with AXI4-Lite registers and edge interrupts
// Function
// [R1] The first port has eight lines, each an input with or without pull-up or an output.
// [R2] First port lines four to seven drive open-drain and ignore any pull-up request.
// [R3] First port lines zero to three drive push-pull when set as outputs.
// [R4] The second port has lines 0-2 and 4-6 only, bit 3 absent, each input or output.
// [R5] The third port has eight lines, each input with or without pull-up or output.
// [R6] All third port lines drive open-drain and lines four to seven have no pull-up.
// [R7] Third port lines 0, 1 and 3 drive the AND of port value and serial signal.
// [R8] Serial clock joins line 0, serial data line 1 and the bus enable strobe line 3.
// [R9] Lines 4 and 6 feed edge latches with selectable edge raising two interrupts.
// [R10] During reset the oscillator is held stopped and on release execution restarts.
// [R11] After reset every line is an input with its driver disabled.
`timescale 1ns/1ps
module tvio_ports
	import tvio_pkg::*;
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        ARST_N_IN,
	// AXI4-Lite slave
	input  wire logic [7:0]  S_AXI_AWADDR_IN,
	input  wire logic        S_AXI_AWVALID_IN,
	output logic             S_AXI_AWREADY_OUT,
	input  wire logic [31:0] S_AXI_WDATA_IN,
	input  wire logic [3:0]  S_AXI_WSTRB_IN,
	input  wire logic        S_AXI_WVALID_IN,
	output logic             S_AXI_WREADY_OUT,
	output logic [1:0]       S_AXI_BRESP_OUT,
	output logic             S_AXI_BVALID_OUT,
	input  wire logic        S_AXI_BREADY_IN,
	input  wire logic [7:0]  S_AXI_ARADDR_IN,
	input  wire logic        S_AXI_ARVALID_IN,
	output logic             S_AXI_ARREADY_OUT,
	output logic [31:0]      S_AXI_RDATA_OUT,
	output logic [1:0]       S_AXI_RRESP_OUT,
	output logic             S_AXI_RVALID_OUT,
	input  wire logic        S_AXI_RREADY_IN,
	// Port pins
	input  wire logic [7:0]  FIRST_PORT_LINES_IN,
	output logic [7:0]       FIRST_PORT_LINES_OUT,
	output logic [7:0]       FIRST_PORT_LINES_OE_OUT,
	output logic [7:0]       FIRST_PORT_LINES_PU_OUT,
	input  wire logic [7:0]  SECOND_PORT_LINES_IN,
	output logic [7:0]       SECOND_PORT_LINES_OUT,
	output logic [7:0]       SECOND_PORT_LINES_OE_OUT,
	output logic [7:0]       SECOND_PORT_LINES_PU_OUT,
	input  wire logic [7:0]  THIRD_PORT_LINES_IN,
	output logic [7:0]       THIRD_PORT_LINES_OUT,
	output logic [7:0]       THIRD_PORT_LINES_OE_OUT,
	output logic [7:0]       THIRD_PORT_LINES_PU_OUT,
	// Serial interface signals
	input  wire logic        SER_CLOCK_IN,
	input  wire logic        SER_DATA_IN,
	input  wire logic        SERIAL_BUS_ENABLE_STROBE_IN,
	// Interrupts and core control
	output logic             POWER_INTERRUPT_INPUT_OUT,
	output logic             REMOTE_INPUT_NONMASKABLE_INTERRUPT_OUT,
	output logic             IRQ_OUT,
	output logic             OSC_ENABLE_OUT,
	output logic             CORE_START_OUT
);

	// Masked byte write
	function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic sel, input logic [7:0] keep);
		wr_byte = (sel && strb[0]) ? (wd[7:0] & keep) : old;
	endfunction

	// Pin drive for one port
	function automatic tvio_drive_t drive(input tvio_port_t p, input logic [7:0] lines,
		input logic [7:0] od, input logic [7:0] pull_ok, input logic [7:0] ser);
		logic [7:0] val;
		val = p.data & ser & lines;
		drive.out = val & ~od;
		drive.oe = p.dir & lines & (~od | ~val);
		drive.pu = ~p.dir & p.pull & pull_ok;
	endfunction

	tvio_port_t     pa_q, pa_d, pb_q, pb_d, pc_q, pc_d;
	tvio_drive_t    da, db, dc;
	tvio_wr_state_t wr_state_q, wr_state_d;
	logic [7:0]     aw_addr_q, aw_addr_d;
	logic [31:0]    w_data_q, w_data_d;
	logic [3:0]     w_strb_q, w_strb_d;
	logic           aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic           awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic           awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0]     bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]    rdata_q, rdata_d;
	logic [1:0]     edge_sel_q, edge_sel_d, stat_q, stat_d, mask_q, mask_d;
	logic [1:0]     prev_q, edge_set, clr;
	logic           armed_q, osc_q, start_q;
	logic [7:0]     ser_mask;

	// Bus handshakes and read and write address decode
	wire aw_hs     = S_AXI_AWVALID_IN && awready_q;
	wire w_hs      = S_AXI_WVALID_IN && wready_q;
	wire ar_hs     = S_AXI_ARVALID_IN && arready_q;
	wire do_write  = (wr_state_q == TVIO_WR_IDLE) && aw_have_q && w_have_q;
	wire [7:0] wa  = {aw_addr_q[7:2], 2'b00};
	wire [7:0] ra  = {S_AXI_ARADDR_IN[7:2], 2'b00};
	wire wr_map    = (wa <= TVIO_OFF_IRQ_MASK);
	wire rd_map    = (ra <= TVIO_OFF_IRQ_MASK);

	// Write address and data capture, either order
	always_comb begin
		wr_state_d = wr_state_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bresp_d = bresp_q;
		bvalid_d = bvalid_q;
		if (aw_hs) begin
			aw_have_d = 1'b1;
			aw_addr_d = S_AXI_AWADDR_IN;
		end
		if (w_hs) begin
			w_have_d = 1'b1;
			w_data_d = S_AXI_WDATA_IN;
			w_strb_d = S_AXI_WSTRB_IN;
		end
		case (wr_state_q)
			TVIO_WR_IDLE: begin
				if (do_write) begin
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					bvalid_d = 1'b1;
					bresp_d = wr_map ? TVIO_RESP_OKAY : TVIO_RESP_SLVERR;
					wr_state_d = TVIO_WR_RESP;
				end
			end
			TVIO_WR_RESP: begin
				if (S_AXI_BREADY_IN) begin
					bvalid_d = 1'b0;
					wr_state_d = TVIO_WR_IDLE;
				end
			end
			default: begin
				wr_state_d = TVIO_WR_IDLE;
				bvalid_d = 1'b0;
			end
		endcase
		awready_d = !aw_have_d && (wr_state_d == TVIO_WR_IDLE);
		wready_d = !w_have_d && (wr_state_d == TVIO_WR_IDLE);
	end

	// Register writes
	wire we = do_write;
	assign pa_d.data = wr_byte(pa_q.data, w_data_q, w_strb_q, we && wa == TVIO_OFF_A_DATA,
		TVIO_A_LINES);
	assign pa_d.dir  = wr_byte(pa_q.dir, w_data_q, w_strb_q, we && wa == TVIO_OFF_A_DIR,
		TVIO_A_LINES); // [R1]
	assign pa_d.pull = wr_byte(pa_q.pull, w_data_q, w_strb_q, we && wa == TVIO_OFF_A_PULL,
		TVIO_A_PULL_OK); // [R2]
	assign pb_d.data = wr_byte(pb_q.data, w_data_q, w_strb_q, we && wa == TVIO_OFF_B_DATA,
		TVIO_B_LINES); // [R4]
	assign pb_d.dir  = wr_byte(pb_q.dir, w_data_q, w_strb_q, we && wa == TVIO_OFF_B_DIR,
		TVIO_B_LINES); // [R4]
	assign pb_d.pull = wr_byte(pb_q.pull, w_data_q, w_strb_q, we && wa == TVIO_OFF_B_PULL,
		TVIO_B_PULL_OK); // [R4]
	assign pc_d.data = wr_byte(pc_q.data, w_data_q, w_strb_q, we && wa == TVIO_OFF_C_DATA,
		TVIO_C_LINES); // [R5]
	assign pc_d.dir  = wr_byte(pc_q.dir, w_data_q, w_strb_q, we && wa == TVIO_OFF_C_DIR,
		TVIO_C_LINES); // [R5]
	assign pc_d.pull = wr_byte(pc_q.pull, w_data_q, w_strb_q, we && wa == TVIO_OFF_C_PULL,
		TVIO_C_PULL_OK); // [R6]
	assign edge_sel_d = (we && w_strb_q[0] && wa == TVIO_OFF_EDGE_SEL) ?
		w_data_q[TVIO_IRQ_BITS-1:0] : edge_sel_q;
	assign mask_d = (we && w_strb_q[0] && wa == TVIO_OFF_IRQ_MASK) ?
		w_data_q[TVIO_IRQ_BITS-1:0] : mask_q;
	assign clr = (we && w_strb_q[0] && wa == TVIO_OFF_IRQ_STAT) ?
		w_data_q[TVIO_IRQ_BITS-1:0] : 2'h0;

	// Edge latches on the two interrupt lines, input direction only
	wire [1:0] cur = {THIRD_PORT_LINES_IN[TVIO_C_REMOTE], THIRD_PORT_LINES_IN[TVIO_C_PWR]};
	wire [1:0] is_in = {~pc_q.dir[TVIO_C_REMOTE], ~pc_q.dir[TVIO_C_PWR]};
	assign edge_set = armed_q ? (is_in & ((edge_sel_q & cur & ~prev_q) |
		(~edge_sel_q & ~cur & prev_q))) : 2'h0; // [R9]
	assign stat_d = (stat_q & ~clr) | edge_set; // [R9]

	// Serial signals ANDed into third port lines
	assign ser_mask = {4'hf, SERIAL_BUS_ENABLE_STROBE_IN, 1'b1, SER_DATA_IN,
		SER_CLOCK_IN}; // [R7] [R8]

	// Pin drive per port
	assign da = drive(pa_q, TVIO_A_LINES, TVIO_A_OD, TVIO_A_PULL_OK, 8'hff); // [R2] [R3]
	assign db = drive(pb_q, TVIO_B_LINES, TVIO_B_OD, TVIO_B_PULL_OK, 8'hff); // [R4]
	assign dc = drive(pc_q, TVIO_C_LINES, TVIO_C_OD, TVIO_C_PULL_OK, ser_mask); // [R6] [R7]

	// Read path
	always_comb begin
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		rvalid_d = rvalid_q && !S_AXI_RREADY_IN;
		if (ar_hs) begin
			rvalid_d = 1'b1;
			rresp_d = rd_map ? TVIO_RESP_OKAY : TVIO_RESP_SLVERR;
			case (ra)
				TVIO_OFF_A_DATA:   rdata_d = {24'h0, pa_q.data};
				TVIO_OFF_A_DIR:    rdata_d = {24'h0, pa_q.dir};
				TVIO_OFF_A_PULL:   rdata_d = {24'h0, pa_q.pull};
				TVIO_OFF_A_PINS:   rdata_d = {24'h0, FIRST_PORT_LINES_IN & TVIO_A_LINES};
				TVIO_OFF_B_DATA:   rdata_d = {24'h0, pb_q.data};
				TVIO_OFF_B_DIR:    rdata_d = {24'h0, pb_q.dir};
				TVIO_OFF_B_PULL:   rdata_d = {24'h0, pb_q.pull};
				TVIO_OFF_B_PINS:   rdata_d = {24'h0, SECOND_PORT_LINES_IN & TVIO_B_LINES};
				TVIO_OFF_C_DATA:   rdata_d = {24'h0, pc_q.data};
				TVIO_OFF_C_DIR:    rdata_d = {24'h0, pc_q.dir};
				TVIO_OFF_C_PULL:   rdata_d = {24'h0, pc_q.pull};
				TVIO_OFF_C_PINS:   rdata_d = {24'h0, THIRD_PORT_LINES_IN & TVIO_C_LINES};
				TVIO_OFF_EDGE_SEL: rdata_d = {30'h0, edge_sel_q};
				TVIO_OFF_IRQ_STAT: rdata_d = {30'h0, stat_q};
				TVIO_OFF_IRQ_MASK: rdata_d = {30'h0, mask_q};
				default:           rdata_d = 32'h0;
			endcase
		end
		arready_d = !rvalid_d;
	end

	// Bus state registers
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			wr_state_q <= TVIO_WR_IDLE;
			{aw_have_q, w_have_q, bvalid_q, rvalid_q} <= 4'h0;
			{awready_q, wready_q, arready_q} <= 3'h0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			{bresp_q, rresp_q} <= 4'h0;
			rdata_q <= 32'h0;
		end else begin
			wr_state_q <= wr_state_d;
			{aw_have_q, w_have_q, bvalid_q, rvalid_q} <= {aw_have_d, w_have_d, bvalid_d, rvalid_d};
			{awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			{bresp_q, rresp_q} <= {bresp_d, rresp_d};
			rdata_q <= rdata_d;
		end
	end

	// Port configuration, all lines inputs after reset
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pa_q <= TVIO_RST_PORT; // [R11]
			pb_q <= TVIO_RST_PORT; // [R11]
			pc_q <= TVIO_RST_PORT; // [R11]
		end else begin
			pa_q <= pa_d;
			pb_q <= pb_d;
			pc_q <= pc_d;
		end
	end

	// Interrupt state and edge history
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			edge_sel_q <= TVIO_RST_IRQ;
			mask_q <= TVIO_RST_IRQ;
			stat_q <= TVIO_RST_IRQ;
			prev_q <= TVIO_RST_IRQ;
			armed_q <= 1'b0;
		end else begin
			edge_sel_q <= edge_sel_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			prev_q <= cur;
			armed_q <= 1'b1; // No edge from the reset value
		end
	end

	// Oscillator hold and restart pulse
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			osc_q <= 1'b0; // [R10]
			start_q <= 1'b0;
		end else begin
			osc_q <= 1'b1; // [R10]
			start_q <= !osc_q; // [R10]
		end
	end

	// Registered pin and interrupt outputs
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			{FIRST_PORT_LINES_OUT, FIRST_PORT_LINES_OE_OUT, FIRST_PORT_LINES_PU_OUT} <= '0;
			{SECOND_PORT_LINES_OUT, SECOND_PORT_LINES_OE_OUT, SECOND_PORT_LINES_PU_OUT} <= '0;
			{THIRD_PORT_LINES_OUT, THIRD_PORT_LINES_OE_OUT, THIRD_PORT_LINES_PU_OUT} <= '0;
			POWER_INTERRUPT_INPUT_OUT <= 1'b0;
			REMOTE_INPUT_NONMASKABLE_INTERRUPT_OUT <= 1'b0;
			IRQ_OUT <= 1'b0;
		end else begin
			{FIRST_PORT_LINES_OUT, FIRST_PORT_LINES_OE_OUT, FIRST_PORT_LINES_PU_OUT} <= da;
			{SECOND_PORT_LINES_OUT, SECOND_PORT_LINES_OE_OUT, SECOND_PORT_LINES_PU_OUT} <= db;
			{THIRD_PORT_LINES_OUT, THIRD_PORT_LINES_OE_OUT, THIRD_PORT_LINES_PU_OUT} <= dc;
			POWER_INTERRUPT_INPUT_OUT <= stat_d[TVIO_IRQ_PWR] && mask_d[TVIO_IRQ_PWR]; // [R9]
			REMOTE_INPUT_NONMASKABLE_INTERRUPT_OUT <=
				stat_d[TVIO_IRQ_REMOTE] && mask_d[TVIO_IRQ_REMOTE]; // [R9]
			IRQ_OUT <= |(stat_d & mask_d);
		end
	end

	// Bus, oscillator enable and core start outputs
	assign S_AXI_AWREADY_OUT = awready_q;
	assign S_AXI_WREADY_OUT = wready_q;
	assign S_AXI_BVALID_OUT = bvalid_q;
	assign S_AXI_BRESP_OUT = bresp_q;
	assign S_AXI_ARREADY_OUT = arready_q;
	assign S_AXI_RVALID_OUT = rvalid_q;
	assign S_AXI_RRESP_OUT = rresp_q;
	assign S_AXI_RDATA_OUT = rdata_q;
	assign OSC_ENABLE_OUT = osc_q;
	assign CORE_START_OUT = start_q;

	// Checks
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	sequence s_pwr_edge;
		armed_q && !pc_q.dir[TVIO_C_PWR] && (edge_sel_q[TVIO_IRQ_PWR] ?
			$rose(THIRD_PORT_LINES_IN[TVIO_C_PWR]) : $fell(THIRD_PORT_LINES_IN[TVIO_C_PWR]));
	endsequence
	sequence s_pwr_flag;
		stat_q[TVIO_IRQ_PWR] ##0 (POWER_INTERRUPT_INPUT_OUT == mask_q[TVIO_IRQ_PWR]);
	endsequence

	AST_DIR_GATES_DRIVE: assert property ( // [R1]
		(FIRST_PORT_LINES_OE_OUT & ~$past(pa_q.dir)) == 8'h0)
		else $error("first port drives a line set as input");
	AST_A_OPEN_DRAIN: assert property (FIRST_PORT_LINES_OE_OUT[7:4] == // [R2]
		($past(pa_q.dir[7:4]) & ~$past(pa_q.data[7:4])) && FIRST_PORT_LINES_PU_OUT[7:4] == 4'h0)
		else $error("first port upper lines not open-drain");
	AST_A_PUSH_PULL: assert property ( // [R3]
		FIRST_PORT_LINES_OE_OUT[3:0] == $past(pa_q.dir[3:0]) &&
		FIRST_PORT_LINES_OUT[3:0] == $past(pa_q.data[3:0]))
		else $error("first port lower lines not push-pull");
	AST_B_BIT3_ABSENT: assert property (SECOND_PORT_LINES_OE_OUT[3] == 1'b0 && // [R4]
		SECOND_PORT_LINES_PU_OUT[3] == 1'b0 && pb_q.dir[3] == 1'b0)
		else $error("second port bit 3 active");
	AST_C_PULLUP: assert property (THIRD_PORT_LINES_PU_OUT == // [R5]
		($past(pc_q.pull) & ~$past(pc_q.dir) & TVIO_C_PULL_OK))
		else $error("third port pull-up wrong");
	AST_C_OPEN_DRAIN: assert property (THIRD_PORT_LINES_OUT == 8'h0) // [R6]
		else $error("third port drives high");
	AST_C_SER_AND: assert property ( // [R7]
		THIRD_PORT_LINES_OE_OUT[1:0] == ($past(pc_q.dir[1:0]) &
		~($past(pc_q.data[1:0]) & $past({SER_DATA_IN, SER_CLOCK_IN}))))
		else $error("serial clock or data not ANDed");
	AST_C_STROBE_AND: assert property ( // [R8]
		THIRD_PORT_LINES_OE_OUT[3] == ($past(pc_q.dir[3]) &&
		!($past(pc_q.data[3]) && $past(SERIAL_BUS_ENABLE_STROBE_IN))))
		else $error("bus enable strobe not ANDed");
	AST_PWR_LATCH: assert property (s_pwr_edge |=> s_pwr_flag) // [R9]
		else $error("power edge not latched");
	AST_CLEAR_HOLDS: assert property (stat_q[TVIO_IRQ_REMOTE] && !clr[TVIO_IRQ_REMOTE] // [R9]
		|=> stat_q[TVIO_IRQ_REMOTE])
		else $error("remote flag lost without clear");
	AST_START_PULSE: assert property (CORE_START_OUT |-> OSC_ENABLE_OUT ##1 // [R10]
		(!CORE_START_OUT && OSC_ENABLE_OUT)[*2])
		else $error("restart pulse wrong");
	AST_WRITE_RESP: assert property (do_write |-> ##1 S_AXI_BVALID_OUT)
		else $error("write response late");

endmodule

// File: tb/tb_top.sv
// Testbench for the three I/O ports: register bus tasks and port scenarios
`timescale 1ns/1ps
module tb_top
	import tvio_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00, wd = 8'h00;
	logic [2:0] ser = 3'h7;
	logic [1:0] rsp;
	logic [31:0] rd_d;
	int bad_count = 0, num_checks = 0, cycles = 0;
	wire awr, wr_r, bvl, arr, rvl, pwr, rem, irq, osc, cst;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [7:0] ao, aoe, apu, bo, boe, bpu, co, coe, cpu, pa, pb, pc;
	tvio_drive_t da, db, dc, ea, eb, ec;

	assign da = '{out: ao, oe: aoe, pu: apu};
	assign db = '{out: bo, oe: boe, pu: bpu};
	assign dc = '{out: co, oe: coe, pu: cpu};

	// Clock generator, 125 MHz
	always #4 clk = ~clk;

	tvio_ports dut (.REF_CLK_IN(clk), .ARST_N_IN(arst_n), .S_AXI_AWADDR_IN(awa),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN({24'h000000, wd}),
		.S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r),
		.S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bvl), .S_AXI_BREADY_IN(brdy),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rvl),
		.S_AXI_RREADY_IN(rrdy), .FIRST_PORT_LINES_IN(pa), .FIRST_PORT_LINES_OUT(ao),
		.FIRST_PORT_LINES_OE_OUT(aoe), .FIRST_PORT_LINES_PU_OUT(apu),
		.SECOND_PORT_LINES_IN(pb), .SECOND_PORT_LINES_OUT(bo), .SECOND_PORT_LINES_OE_OUT(boe),
		.SECOND_PORT_LINES_PU_OUT(bpu), .THIRD_PORT_LINES_IN(pc), .THIRD_PORT_LINES_OUT(co),
		.THIRD_PORT_LINES_OE_OUT(coe), .THIRD_PORT_LINES_PU_OUT(cpu),
		.SER_CLOCK_IN(ser[0]), .SER_DATA_IN(ser[1]), .SERIAL_BUS_ENABLE_STROBE_IN(ser[2]),
		.POWER_INTERRUPT_INPUT_OUT(pwr), .REMOTE_INPUT_NONMASKABLE_INTERRUPT_OUT(rem),
		.IRQ_OUT(irq), .OSC_ENABLE_OUT(osc), .CORE_START_OUT(cst));

	tvio_board board (.clk_in(clk), .drv_a_in(da), .drv_b_in(db), .drv_c_in(dc),
		.ext_a_in(ea), .ext_b_in(eb), .ext_c_in(ec),
		.pins_a_out(pa), .pins_b_out(pb), .pins_c_out(pc));

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// Write one register; payload held until each channel is taken
	task automatic wr_raw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		forever begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr_r)
				wv <= 1'b0;
			if (bvl) begin
				rsp = br;
				brdy <= 1'b0;
				break;
			end
		end
	endtask

	// Read one register
	task automatic rd_raw(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		forever begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rvl) begin
				rd_d = rdat;
				rsp = rr;
				rrdy <= 1'b0;
				break;
			end
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_raw(a, d);
		chk({30'h0, rsp}, {30'h0, TVIO_RESP_OKAY});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rd_raw(a);
		chk(rd_d, {24'h000000, exp});
		chk({30'h0, rsp}, {30'h0, TVIO_RESP_OKAY});
	endtask

	// Let register writes reach the pin drivers
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Main sequence
	initial begin
		ea = '{out: 8'h3c, oe: 8'hff, pu: 8'h00};
		eb = '{out: 8'hff, oe: 8'hff, pu: 8'h00};
		ec = '{out: 8'h40, oe: 8'h50, pu: 8'h00};
		repeat (20) @(posedge clk);
		#1;
		chk_bit(osc, 1'b0);
		@(posedge clk);
		arst_n <= 1'b1;
		// Oscillator and restart pulse both rise at the first edge after release
		@(posedge clk);
		#1;
		chk_bit(osc, 1'b1);
		chk_bit(cst, 1'b1);
		@(posedge clk);
		#1;
		chk_bit(cst, 1'b0);
		chk({aoe, boe, coe}, 24'h0);
		chk({apu, bpu, cpu}, 24'h0);
		rd(TVIO_OFF_A_DIR, 8'h00);
		rd(TVIO_OFF_A_PINS, 8'h3c);
		rd(TVIO_OFF_B_PINS, 8'h77);
		wr(TVIO_OFF_A_PINS, 8'h00);
		rd(TVIO_OFF_A_PINS, 8'h3c);
		ea.oe <= 8'h00;
		eb.oe <= 8'h00;
		// Pull-up requests on every line of every port
		wr(TVIO_OFF_A_PULL, 8'hff);
		wr(TVIO_OFF_B_PULL, 8'hff);
		wr(TVIO_OFF_C_PULL, 8'hff);
		settle();
		chk({apu, bpu, cpu}, 24'h0f770f);
		rd(TVIO_OFF_C_PULL, 8'h0f);
		// Port A mixed push-pull and open-drain drive
		wr(TVIO_OFF_A_DATA, 8'ha5);
		wr(TVIO_OFF_A_DIR, 8'hff);
		settle();
		chk({ao, aoe}, {8'h05, 8'h0f | (~8'ha5 & 8'hf0)});
		wr(TVIO_OFF_B_DATA, 8'hff);
		wr(TVIO_OFF_B_DIR, 8'hff);
		rd(TVIO_OFF_B_DIR, 8'h77);
		settle();
		chk({bo, boe}, 16'h7777);
		// Port C open-drain with serial signals ANDed on lines 0, 1 and 3
		wr(TVIO_OFF_C_DATA, 8'h2f);
		wr(TVIO_OFF_C_DIR, 8'haf);
		settle();
		chk({co, coe}, {8'h00, 8'h80});
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			ser <= 3'h7 & ~(3'h1 << i);
			settle();
			chk({co, coe}, {8'h00, 8'h80 | (8'h01 << ((i == 2) ? 3 : i))});
		end
		@(posedge clk);
		ser <= 3'h7;
		// Edge latches: line 4 rising, line 6 falling
		wr(TVIO_OFF_EDGE_SEL, 8'h01);
		wr(TVIO_OFF_IRQ_MASK, 8'h03);
		@(posedge clk);
		ec.out <= 8'h50;
		settle();
		chk({pwr, rem, irq}, 3'b101);
		rd(TVIO_OFF_IRQ_STAT, 8'h01);
		wr(TVIO_OFF_IRQ_STAT, 8'h01);
		settle();
		chk_bit(irq, 1'b0);
		@(posedge clk);
		ec.out <= 8'h00;
		settle();
		chk({pwr, rem, irq}, 3'b011);
		rd(TVIO_OFF_IRQ_STAT, 8'h02);
		wr(TVIO_OFF_IRQ_MASK, 8'h01);
		settle();
		chk({pwr, rem, irq}, 3'b000);
		wr(TVIO_OFF_IRQ_STAT, 8'h03);
		rd(TVIO_OFF_IRQ_STAT, 8'h00);
		// Unmapped place answers with an error
		wr_raw(8'h3c, 8'hff);
		chk({30'h0, rsp}, {30'h0, TVIO_RESP_SLVERR});
		rd_raw(8'h40);
		chk({rd_d[29:0], rsp}, {30'h0, TVIO_RESP_SLVERR});
		// Second reset in mid-run
		@(posedge clk);
		arst_n <= 1'b0;
		settle();
		chk({osc, aoe, boe, coe}, 25'h0);
		// Release again: restart pulse and reset register contents
		@(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk({osc, cst}, 2'b11);
		rd(TVIO_OFF_C_DIR, 8'h00);
		rd(TVIO_OFF_IRQ_MASK, 8'h00);
		// Line 6 set to rising edge after the restart
		wr(TVIO_OFF_EDGE_SEL, 8'h02);
		wr(TVIO_OFF_IRQ_MASK, 8'h02);
		@(posedge clk);
		ec.out <= 8'h40;
		settle();
		chk({pwr, rem, irq}, 3'b011);
		end_of_test();
	end
endmodule

// File: tb/tvio_board.sv
// Board model: resolves each port line from chip drive, external drive and pull-ups
`timescale 1ns/1ps
module tvio_board
	import tvio_pkg::*;
(
	input  wire logic        clk_in,
	input  wire tvio_drive_t drv_a_in,
	input  wire tvio_drive_t drv_b_in,
	input  wire tvio_drive_t drv_c_in,
	input  wire tvio_drive_t ext_a_in,
	input  wire tvio_drive_t ext_b_in,
	input  wire tvio_drive_t ext_c_in,
	output logic [7:0]       pins_a_out,
	output logic [7:0]       pins_b_out,
	output logic [7:0]       pins_c_out
);
	logic tog_q = 1'b0;

	// Floating lines change every cycle so no stale level is read back
	always @(posedge clk_in) begin
		tog_q <= ~tog_q;
	end

	// Chip drive wins, then board drive, then pull-up, else floating
	function automatic logic [7:0] level(tvio_drive_t d, tvio_drive_t e, logic t);
		logic [7:0] rel;
		rel = ~d.oe & ~e.oe;
		return (d.oe & d.out) | (~d.oe & e.oe & e.out) | (rel & d.pu)
			| (rel & ~d.pu & {4{t, ~t}});
	endfunction

	// Resolved line levels fed back to the chip
	assign pins_a_out = level(drv_a_in, ext_a_in, tog_q);
	assign pins_b_out = level(drv_b_in, ext_b_in, tog_q);
	assign pins_c_out = level(drv_c_in, ext_c_in, tog_q);
endmodule
